// [rx_overhead_pkg.sv]
// Package for the receive overhead capture bank: register indices, field
// positions, reset values and the carrier structs of the framer side.
// Assumes one bank per port, behind an APB slave with 32-bit data.
package rx_overhead_pkg;

   // Printed offsets are register indices; byte address is four times the index
   localparam logic [11:0] IDX_CHANNEL_MONITOR = 12'h060;
   localparam logic [11:0] IDX_DATA_LINK = 12'h062;
   localparam logic [11:0] IDX_BIT_ORIENTED = 12'h063;
   localparam logic [11:0] IDX_CAPTURE_ONE = 12'h064;
   localparam logic [11:0] IDX_CAPTURE_TWO = 12'h065;
   localparam logic [11:0] IDX_CAPTURE_THREE = 12'h066;
   localparam logic [11:0] IDX_INTL_ODD = 12'h067;
   localparam logic [11:0] IDX_REMOTE_ALARM = 12'h068;
   localparam logic [11:0] IDX_SPARE4 = 12'h069;
   localparam logic [11:0] IDX_MONITOR_SELECT = 12'h070;
   localparam logic [11:0] IDX_MASTER_MODE = 12'h080;
   localparam logic [11:0] IDX_CONTROL_ONE = 12'h081;
   localparam logic [11:0] PORT_STRIDE = 12'h200;
   localparam int PORT_COUNT = 8;

   // Field positions
   localparam int MODE_E1_BIT = 0;
   localparam int FRAME_FORMAT_BIT = 5;
   localparam int CRC4_ENABLE_BIT = 3;
   localparam int SI_BIT = 7;
   localparam int REMOTE_ALARM_BIT = 5;
   localparam int SA4_BIT = 4;

   // Widths and reset values
   localparam int CHANNEL_BITS = 8;
   localparam int FS_BITS = 6;
   localparam int SEARCH_COUNT_BITS = 6;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [4:0] SELECT_RESET = 5'h00;

   // Timeslot 0 byte of one E1 frame, with its frame number in the multiframe
   typedef struct packed {
      logic strobe;
      logic [3:0] frame_num;
      logic [7:0] value;
   } ts0_capture_s;

   // E1 synchronizer state as seen by the bank
   typedef struct packed {
      logic crc_mf_hunt;
      logic cas_mf_hunt;
      logic fas_hunt;
      logic search_timeout;
      logic crc_sync_gained;
   } sync_state_s;

endpackage : rx_overhead_pkg

// [bit_collector.sv]
// Serial-to-parallel collector for captured line bits.
// Assumes one bit per strobe cycle; align marks the first bit of a word.
`timescale 1ns/1ps
module bit_collector #(
   parameter int WIDTH = 8,
   parameter bit LSB_FIRST = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic bit_strobe,
   input wire logic bit_in,
   input wire logic align,
   output logic [WIDTH-1:0] word,
   output logic word_done
);
   localparam int CW = $clog2(WIDTH + 1);
   logic [WIDTH-1:0] next_word;
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic next_done;

   initial begin
      if (WIDTH < 2 || WIDTH > 16) $error("bit_collector: WIDTH out of range");
   end

   always_comb begin
      next_word = word;
      next_count = count;
      next_done = 1'b0;
      if (bit_strobe) begin
         // First-received bit ends in bit 0 when LSB first, else last bit does
         if (LSB_FIRST) next_word = {bit_in, word[WIDTH-1:1]};
         else next_word = {word[WIDTH-2:0], bit_in};
         next_count = align ? CW'(1) : count + CW'(1);
         // Done is registered so that word already holds the last bit when it is seen
         next_done = (next_count == CW'(WIDTH));
         if (next_done) next_count = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word <= '0;
         count <= '0;
         word_done <= 1'b0;
      end else begin
         word <= next_word;
         count <= next_count;
         word_done <= next_done;
      end
   end
endmodule : bit_collector

// [crc_search_counter.sv]
// Saturating count of expired CRC-4 multiframe searches.
// Assumes timeout and sync strobes come from the receive synchronizer.
`timescale 1ns/1ps
module crc_search_counter #(
   parameter int WIDTH = 6
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic search_timeout,
   input wire logic sync_gained,
   input wire logic crc4_enable,
   output logic [WIDTH-1:0] count
);
   logic [WIDTH-1:0] next_count;

   initial begin
      if (WIDTH < 2) $error("crc_search_counter: WIDTH too small");
   end

   always_comb begin
      next_count = count;
      if (sync_gained || !crc4_enable) next_count = '0;
      else if (search_timeout && count != '1) next_count = count + WIDTH'(1);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) count <= '0;
      else count <= next_count;
   end
endmodule : crc_search_counter

// [rx_overhead_capture_regs.sv]
// Receive overhead capture bank for one port of the T1/E1 framer.
// Assumes framer-side strobes are synchronous to pclk and one cycle wide.
`timescale 1ns/1ps
module rx_overhead_capture_regs
   import rx_overhead_pkg::*;
#(
   parameter int PORT_INDEX = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic line_bit,
   input wire logic line_bit_strobe,
   input wire logic [4:0] line_slot,
   input wire logic line_slot_first,
   input wire logic link_bit_strobe,
   input wire logic fs_bit_strobe,
   input wire logic multiframe_end,
   input wire logic boc_valid,
   input wire logic [5:0] boc_code,
   input wire logic slc_strobe,
   input wire logic [23:0] slc_word,
   input wire rx_overhead_pkg::ts0_capture_s ts0,
   input wire rx_overhead_pkg::sync_state_s sync_state,
   output logic e1_mode,
   output logic d4_framing,
   output logic crc4_enable
);
   import rx_overhead_pkg::*;

   localparam logic [11:0] PORT_BASE = 12'((PORT_INDEX - 1) * 32'h200);

   initial begin
      if (PORT_INDEX < 1 || PORT_INDEX > PORT_COUNT) $error("PORT_INDEX out of range");
   end

   // Index within this port's bank, or an out-of-range value for foreign addresses
   function automatic logic [11:0] local_index(input logic [15:0] addr);
      logic [11:0] rel;
      rel = addr[13:2] - PORT_BASE;
      if (addr[1:0] != 2'b00 || addr[15:14] != 2'b00 || rel >= PORT_STRIDE) rel = 12'hfff;
      return rel;
   endfunction : local_index

   // Stored state
   logic [7:0] channel_monitor;
   logic [7:0] data_link;
   logic [5:0] bit_oriented;
   logic [23:0] slc_link;
   logic [7:0] align_byte;
   logic [7:0] nonalign_byte;
   logic [7:0] intl_even;
   logic [7:0] intl_odd;
   logic [7:0] remote_alarm;
   logic [7:0] spare4;
   logic [4:0] monitor_select;
   logic [7:0] master_mode;
   logic [7:0] control_one;
   logic [7:0] next_channel_monitor;
   logic [7:0] next_data_link;
   logic [5:0] next_bit_oriented;
   logic [23:0] next_slc_link;
   logic [7:0] next_align_byte;
   logic [7:0] next_nonalign_byte;
   logic [7:0] next_intl_even;
   logic [7:0] next_intl_odd;
   logic [7:0] next_remote_alarm;
   logic [7:0] next_spare4;
   logic [4:0] next_monitor_select;
   logic [7:0] next_master_mode;
   logic [7:0] next_control_one;
   logic [31:0] next_prdata;
   logic next_pslverr;

   logic [7:0] monitor_word;
   logic monitor_done;
   logic [7:0] link_word;
   logic link_done;
   logic [5:0] fs_word;
   logic [5:0] search_count;
   logic [7:0] sync_status;
   logic [11:0] idx;
   logic mapped;
   logic setup_phase;
   logic write_now;
   logic [2:0] pair;

   assign e1_mode = master_mode[MODE_E1_BIT];
   assign d4_framing = control_one[FRAME_FORMAT_BIT];
   assign crc4_enable = control_one[CRC4_ENABLE_BIT];
   assign pair = ts0.frame_num[3:1];

   bit_collector #(.WIDTH(CHANNEL_BITS), .LSB_FIRST(1'b0)) u_monitor (
      .pclk(pclk),
      .presetn(presetn),
      .bit_strobe(line_bit_strobe && line_slot == monitor_select),
      .bit_in(line_bit),
      .align(line_slot_first),
      .word(monitor_word),
      .word_done(monitor_done)
   );

   bit_collector #(.WIDTH(CHANNEL_BITS), .LSB_FIRST(1'b1)) u_link (
      .pclk(pclk),
      .presetn(presetn),
      .bit_strobe(link_bit_strobe && !d4_framing),
      .bit_in(line_bit),
      .align(1'b0),
      .word(link_word),
      .word_done(link_done)
   );

   // Fs bits have no word boundary of their own; the multiframe end latches them
   bit_collector #(.WIDTH(FS_BITS), .LSB_FIRST(1'b1)) u_fs (
      .pclk(pclk),
      .presetn(presetn),
      .bit_strobe(fs_bit_strobe && d4_framing),
      .bit_in(line_bit),
      .align(1'b0),
      .word(fs_word),
      .word_done()
   );

   crc_search_counter #(.WIDTH(SEARCH_COUNT_BITS)) u_search (
      .pclk(pclk),
      .presetn(presetn),
      .search_timeout(sync_state.search_timeout),
      .sync_gained(sync_state.crc_sync_gained),
      .crc4_enable(crc4_enable),
      .count(search_count)
   );

   // Live status, never latched, so a read shows the synchronizer this cycle
   assign sync_status = {search_count[5:2], search_count[0],
                         sync_state.crc_mf_hunt,
                         sync_state.cas_mf_hunt,
                         sync_state.fas_hunt};

   // Line-side capture
   always_comb begin
      next_channel_monitor = channel_monitor;
      next_data_link = data_link;
      next_bit_oriented = bit_oriented;
      next_slc_link = slc_link;
      next_align_byte = align_byte;
      next_nonalign_byte = nonalign_byte;
      next_intl_even = intl_even;
      next_intl_odd = intl_odd;
      next_remote_alarm = remote_alarm;
      next_spare4 = spare4;
      if (monitor_done) next_channel_monitor = monitor_word;
      if (!e1_mode && !d4_framing && link_done) next_data_link = link_word;
      if (!e1_mode && d4_framing && multiframe_end) next_data_link = {2'b00, fs_word};
      if (!e1_mode && boc_valid) next_bit_oriented = boc_code;
      if (!e1_mode && slc_strobe) next_slc_link = slc_word;
      if (e1_mode && ts0.strobe) begin
         if (!ts0.frame_num[0]) begin
            next_align_byte = ts0.value;
            next_intl_even[pair] = ts0.value[SI_BIT];
         end else begin
            next_nonalign_byte = ts0.value;
            next_intl_odd[pair] = ts0.value[SI_BIT];
            next_remote_alarm[pair] = ts0.value[REMOTE_ALARM_BIT];
            next_spare4[pair] = ts0.value[SA4_BIT];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_monitor <= BYTE_RESET;
         data_link <= BYTE_RESET;
         bit_oriented <= BYTE_RESET[5:0];
         slc_link <= {3{BYTE_RESET}};
         align_byte <= BYTE_RESET;
         nonalign_byte <= BYTE_RESET;
         intl_even <= BYTE_RESET;
         intl_odd <= BYTE_RESET;
         remote_alarm <= BYTE_RESET;
         spare4 <= BYTE_RESET;
      end else begin
         channel_monitor <= next_channel_monitor;
         data_link <= next_data_link;
         bit_oriented <= next_bit_oriented;
         slc_link <= next_slc_link;
         align_byte <= next_align_byte;
         nonalign_byte <= next_nonalign_byte;
         intl_even <= next_intl_even;
         intl_odd <= next_intl_odd;
         remote_alarm <= next_remote_alarm;
         spare4 <= next_spare4;
      end
   end

   // APB slave: read data is taken in the setup cycle so the access phase
   // completes with no wait state while prdata still comes from a flip-flop.
   assign idx = local_index(paddr);
   assign setup_phase = psel && !penable;
   assign write_now = psel && penable && pwrite && pstrb[0];
   assign pready = 1'b1;

   always_comb begin
      next_prdata = prdata;
      next_pslverr = pslverr;
      mapped = 1'b1;
      next_monitor_select = monitor_select;
      next_master_mode = master_mode;
      next_control_one = control_one;
      if (setup_phase) begin
         next_prdata = '0;
         case (idx)
            IDX_CHANNEL_MONITOR: next_prdata[7:0] = channel_monitor;
            IDX_DATA_LINK: next_prdata[7:0] = e1_mode ? sync_status : data_link;
            IDX_BIT_ORIENTED: next_prdata[7:0] = e1_mode ? 8'h00 : {2'b00, bit_oriented};
            IDX_CAPTURE_ONE: next_prdata[7:0] = e1_mode ? align_byte : slc_link[7:0];
            IDX_CAPTURE_TWO: next_prdata[7:0] = e1_mode ? nonalign_byte : slc_link[15:8];
            IDX_CAPTURE_THREE: next_prdata[7:0] = e1_mode ? intl_even : slc_link[23:16];
            IDX_INTL_ODD: next_prdata[7:0] = intl_odd;
            IDX_REMOTE_ALARM: next_prdata[7:0] = remote_alarm;
            IDX_SPARE4: next_prdata[7:0] = spare4;
            IDX_MONITOR_SELECT: next_prdata[7:0] = {3'b000, monitor_select};
            IDX_MASTER_MODE: next_prdata[7:0] = master_mode;
            IDX_CONTROL_ONE: next_prdata[7:0] = control_one;
            default: mapped = 1'b0;
         endcase
         next_pslverr = !mapped;
      end
      // Capture registers have no write path; only the three control bytes take data
      if (write_now && !pslverr) begin
         case (idx)
            IDX_MONITOR_SELECT: next_monitor_select = pwdata[4:0];
            IDX_MASTER_MODE: next_master_mode = pwdata[7:0];
            IDX_CONTROL_ONE: next_control_one = pwdata[7:0];
            default: next_control_one = control_one;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pslverr <= 1'b0;
         monitor_select <= SELECT_RESET;
         master_mode <= BYTE_RESET;
         control_one <= BYTE_RESET;
      end else begin
         prdata <= next_prdata;
         pslverr <= next_pslverr;
         monitor_select <= next_monitor_select;
         master_mode <= next_master_mode;
         control_one <= next_control_one;
      end
   end

   // Checks
   chk_boc_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && idx == IDX_BIT_ORIENTED) |-> prdata[7:6] == 2'b00)
      else $error("code register upper bits not zero");

   chk_status_live: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_phase && idx == IDX_DATA_LINK && e1_mode)
      |=> prdata[7:0] == $past(sync_status))
      else $error("E1 status read not live");

   chk_counter_sat: assert property (@(posedge pclk) disable iff (!presetn)
      (search_count == 6'h3f && crc4_enable && !sync_state.crc_sync_gained)
      |=> search_count == 6'h3f)
      else $error("search counter wrapped");

   chk_counter_step: assert property (@(posedge pclk) disable iff (!presetn)
      (sync_state.search_timeout && crc4_enable && !sync_state.crc_sync_gained
       && search_count != 6'h3f) |=> search_count == $past(search_count) + 6'h01)
      else $error("search counter did not advance");

   chk_counter_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (sync_state.crc_sync_gained || !crc4_enable) |=> search_count == 6'h00)
      else $error("search counter not cleared");

   chk_hunt_bits: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_phase && idx == IDX_DATA_LINK && e1_mode)
      |=> prdata[2:0] == $past({sync_state.crc_mf_hunt, sync_state.cas_mf_hunt,
                                sync_state.fas_hunt}))
      else $error("hunt bits not live");

   chk_d4_link_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (!e1_mode && d4_framing && !multiframe_end) |=> data_link == $past(data_link))
      else $error("D4 link register moved off multiframe end");

   chk_d4_link_load: assert property (@(posedge pclk) disable iff (!presetn)
      (!e1_mode && d4_framing && multiframe_end) |=> data_link == {2'b00, $past(fs_word)})
      else $error("D4 link register missed Fs bits");

   chk_monitor_load: assert property (@(posedge pclk) disable iff (!presetn)
      monitor_done |=> channel_monitor == $past(monitor_word))
      else $error("monitor byte not loaded");

   chk_si_odd: assert property (@(posedge pclk) disable iff (!presetn)
      (e1_mode && ts0.strobe && ts0.frame_num[0])
      |=> intl_odd[$past(pair)] == $past(ts0.value[SI_BIT]))
      else $error("odd frame Si bit misplaced");

   chk_capture_no_write: assert property (@(posedge pclk) disable iff (!presetn)
      (write_now && idx == IDX_SPARE4 && !(e1_mode && ts0.strobe))
      |=> spare4 == $past(spare4))
      else $error("read-only register took a write");

   chk_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_phase && idx == 12'hfff) |=> pslverr && prdata == 32'h0)
      else $error("foreign address not refused");

endmodule : rx_overhead_capture_regs

// [rx_line_source.sv]
// Line-side model: the remote transmitter as seen through the receive framer.
// Assumes one caller at a time; every change lands just after a rising pclk edge.
`timescale 1ns/1ps
module rx_line_source (
   input wire logic pclk,
   output logic line_bit,
   output logic line_bit_strobe,
   output logic [4:0] line_slot,
   output logic line_slot_first,
   output logic link_bit_strobe,
   output logic fs_bit_strobe,
   output logic multiframe_end,
   output logic boc_valid,
   output logic [5:0] boc_code,
   output logic slc_strobe,
   output logic [23:0] slc_word,
   output rx_overhead_pkg::ts0_capture_s ts0,
   output rx_overhead_pkg::sync_state_s sync_state
);
   import rx_overhead_pkg::*;

   initial begin
      {line_bit, line_bit_strobe, line_slot, line_slot_first, link_bit_strobe} = '0;
      {fs_bit_strobe, multiframe_end, boc_valid, boc_code, slc_strobe, slc_word} = '0;
      ts0 = '0;
      sync_state = '0;
   end

   // Kind 0 payload bit, 1 link bit, 2 Fs bit; data is inverted once the strobe drops
   task automatic send_bit(input int kind, input logic [4:0] slot, input logic first,
                           input logic b);
      @(posedge pclk);
      line_bit <= b;
      line_slot <= slot;
      line_slot_first <= first;
      line_bit_strobe <= (kind == 0);
      link_bit_strobe <= (kind == 1);
      fs_bit_strobe <= (kind == 2);
      @(posedge pclk);
      line_bit <= ~b;
      line_slot <= ~slot;
      {line_slot_first, line_bit_strobe, link_bit_strobe, fs_bit_strobe} <= 4'h0;
   endtask : send_bit

   // Kind 0 multiframe boundary, 1 search timeout, 2 sync gained
   task automatic pulse_event(input int which);
      @(posedge pclk);
      multiframe_end <= (which == 0);
      sync_state.search_timeout <= (which == 1);
      sync_state.crc_sync_gained <= (which == 2);
      @(posedge pclk);
      multiframe_end <= 1'b0;
      sync_state.search_timeout <= 1'b0;
      sync_state.crc_sync_gained <= 1'b0;
   endtask : pulse_event

   task automatic send_boc(input logic [5:0] code, input logic valid);
      @(posedge pclk);
      boc_code <= code;
      boc_valid <= valid;
      @(posedge pclk);
      boc_code <= ~code;
      boc_valid <= 1'b0;
   endtask : send_boc

   task automatic send_slc(input logic [23:0] w);
      @(posedge pclk);
      slc_word <= w;
      slc_strobe <= 1'b1;
      @(posedge pclk);
      slc_word <= ~w;
      slc_strobe <= 1'b0;
   endtask : send_slc

   task automatic send_ts0(input logic [3:0] f, input logic [7:0] v);
      @(posedge pclk);
      ts0 <= '{1'b1, f, v};
      @(posedge pclk);
      ts0 <= '{1'b0, ~f, ~v};
   endtask : send_ts0

   task automatic set_hunt(input logic [2:0] h);
      @(posedge pclk);
      sync_state.crc_mf_hunt <= h[2];
      sync_state.cas_mf_hunt <= h[1];
      sync_state.fas_hunt <= h[0];
   endtask : set_hunt

endmodule : rx_line_source

// [rx_overhead_capture_regs_tb_top.sv]
// Self-checking bench for one port of the receive overhead capture bank.
// Assumes rx_line_source plays the line side and this bench is the APB host.
`timescale 1ns/1ps
module rx_overhead_capture_regs_tb_top;
   import rx_overhead_pkg::*;
   localparam int PORT = 3;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata, rd, v;
   logic pready, pslverr, line_bit, line_bit_strobe, line_slot_first, link_bit_strobe, err;
   logic fs_bit_strobe, multiframe_end, boc_valid, slc_strobe, e1_mode, d4_framing, crc4_enable;
   logic [4:0] line_slot, sel;
   logic [5:0] boc_code, search_cnt;
   logic [23:0] slc_word;
   ts0_capture_s ts0;
   sync_state_s sync_state;
   int failures = 0;
   int checks_done = 0;
   logic [31:0] seed = 32'h00009c7a;
   logic [7:0] t1_reg [12'h060:12'h066];
   logic [7:0] e1_reg [12'h064:12'h069];
   logic [2:0] hunt = 3'h0;
   logic e1, crc_on;

   rx_overhead_capture_regs #(.PORT_INDEX(PORT)) i_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .line_bit(line_bit), .line_bit_strobe(line_bit_strobe), .line_slot(line_slot),
      .line_slot_first(line_slot_first), .link_bit_strobe(link_bit_strobe),
      .fs_bit_strobe(fs_bit_strobe), .multiframe_end(multiframe_end), .boc_valid(boc_valid),
      .boc_code(boc_code), .slc_strobe(slc_strobe), .slc_word(slc_word), .ts0(ts0),
      .sync_state(sync_state), .e1_mode(e1_mode), .d4_framing(d4_framing),
      .crc4_enable(crc4_enable));

   rx_line_source i_line (.pclk(pclk), .line_bit(line_bit), .line_bit_strobe(line_bit_strobe),
      .line_slot(line_slot), .line_slot_first(line_slot_first),
      .link_bit_strobe(link_bit_strobe), .fs_bit_strobe(fs_bit_strobe),
      .multiframe_end(multiframe_end), .boc_valid(boc_valid), .boc_code(boc_code),
      .slc_strobe(slc_strobe), .slc_word(slc_word), .ts0(ts0), .sync_state(sync_state));

   initial begin
      forever #5 pclk = ~pclk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   task automatic report_and_stop();
      if (failures == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         $display("ERROR %s expected %h seen %h", name, want, seen);
         failures++;
      end
   endtask : check

   task automatic apb(input logic wr, input logic [11:0] idx, input int port,
                      input logic [31:0] wd, output logic [31:0] rdata, output logic rerr);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= 16'(({4'h0, idx} + 16'(PORT_STRIDE) * 16'(port - 1)) << 2);
      pwdata <= wd;
      pstrb <= 4'hf;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 20) begin
            failures++;
            report_and_stop();
         end
         @(posedge pclk);
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] idx, input logic [31:0] d);
      apb(1'b1, idx, PORT, d, rd, err);
   endtask : wr

   task automatic compare_bank();
      logic [7:0] want;
      for (int i = 12'h060; i <= 12'h069; i++) begin
         if (i == 12'h061) want = 8'h00;
         else if (e1 && i == 12'h062) want = {search_cnt[5:2], search_cnt[0], hunt};
         else if (e1 && i == 12'h063) want = 8'h00;
         else if (e1 && i >= 12'h064) want = e1_reg[i];
         else if (!e1 && i <= 12'h066) want = t1_reg[i];
         else continue;
         apb(1'b0, 12'(i), PORT, 32'h0, rd, err);
         check($sformatf("reg %h", i), rd, {24'h0, want});
         check($sformatf("err %h", i), {31'h0, err}, {31'h0, i == 12'h061});
      end
   endtask : compare_bank

   task automatic do_reset();
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      foreach (t1_reg[i]) t1_reg[i] = 8'h00;
      foreach (e1_reg[i]) e1_reg[i] = 8'h00;
      search_cnt = 6'h00;
      e1 = 1'b0;
      crc_on = 1'b0;
   endtask : do_reset

   task automatic send_byte(input int kind, input logic [4:0] slot, input logic [7:0] b,
                            input logic msb_first);
      for (int k = 0; k < 8; k++) i_line.send_bit(kind, slot, k == 0, msb_first ? b[7-k] : b[k]);
   endtask : send_byte

   task automatic send_frame(input logic [3:0] f, input logic [7:0] b);
      i_line.send_ts0(f, b);
      if (!e1) return;
      if (f[0] == 1'b0) begin
         e1_reg[12'h064] = b;
         e1_reg[12'h066][f[3:1]] = b[SI_BIT];
      end else begin
         e1_reg[12'h065] = b;
         e1_reg[12'h067][f[3:1]] = b[SI_BIT];
         e1_reg[12'h068][f[3:1]] = b[REMOTE_ALARM_BIT];
         e1_reg[12'h069][f[3:1]] = b[SA4_BIT];
      end
   endtask : send_frame

   task automatic timeouts(input int n);
      repeat (n) begin
         i_line.pulse_event(1);
         if (!crc_on) search_cnt = 6'h00;
         else if (search_cnt != 6'h3f) search_cnt++;
      end
   endtask : timeouts

   initial begin
      repeat (50000) @(posedge pclk);
      failures++;
      report_and_stop();
   end

   initial begin
      do_reset();
      compare_bank();
      for (int i = 12'h060; i <= 12'h069; i++) wr(12'(i), rnd());
      compare_bank();
      apb(1'b0, 12'h07f, PORT, 32'h0, rd, err);
      check("unmapped", {rd[30:0], err}, 32'h1);
      apb(1'b0, IDX_BIT_ORIENTED, 1, 32'h0, rd, err);
      check("other port", {rd[30:0], err}, 32'h1);
      sel = 5'(rnd() % 24);
      wr(IDX_MONITOR_SELECT, {27'h0, sel});
      v = rnd();
      // A neighbouring slot sent afterwards must not overwrite the monitor byte
      send_byte(0, sel, v[7:0], 1'b1);
      send_byte(0, sel ^ 5'h01, v[15:8], 1'b1);
      t1_reg[12'h060] = v[7:0];
      send_byte(1, 5'h00, v[23:16], 1'b0);
      t1_reg[12'h062] = v[23:16];
      send_frame(4'h0, v[31:24]);
      i_line.send_boc(v[5:0], 1'b1);
      i_line.send_boc(~v[5:0], 1'b0);
      t1_reg[12'h063] = {2'b00, v[5:0]};
      v = rnd();
      i_line.send_slc(v[23:0]);
      {t1_reg[12'h066], t1_reg[12'h065], t1_reg[12'h064]} = v[23:0];
      compare_bank();
      wr(IDX_CONTROL_ONE, 32'h00000020);
      @(posedge pclk);
      check("d4 select", {31'h0, d4_framing}, 32'h1);
      for (int k = 0; k < 6; k++) i_line.send_bit(2, 5'h00, 1'b0, v[k]);
      compare_bank();
      i_line.pulse_event(0);
      t1_reg[12'h062] = {2'b00, v[5:0]};
      compare_bank();
      wr(IDX_MASTER_MODE, 32'h00000001);
      wr(IDX_CONTROL_ONE, 32'h00000008);
      e1 = 1'b1;
      crc_on = 1'b1;
      @(posedge pclk);
      check("mode outputs", {30'h0, e1_mode, crc4_enable}, 32'h3);
      for (int f = 0; f < 16; f++) send_frame(4'(f), 8'(rnd()));
      send_frame(4'h3, 8'(rnd()));
      hunt = 3'(rnd());
      i_line.set_hunt(hunt);
      timeouts(5);
      compare_bank();
      hunt = ~hunt;
      i_line.set_hunt(hunt);
      timeouts(65);
      compare_bank();
      i_line.pulse_event(2);
      search_cnt = 6'h00;
      timeouts(3);
      compare_bank();
      // Host gives up the CRC-4 search by turning CRC-4 mode off
      wr(IDX_CONTROL_ONE, 32'h00000000);
      crc_on = 1'b0;
      search_cnt = 6'h00;
      timeouts(1);
      compare_bank();
      do_reset();
      compare_bank();
      report_and_stop();
   end

endmodule : rx_overhead_capture_regs_tb_top
